// >>> rtl/vim_pkg.sv
// constants for the vectored interrupt merger: vector register address,
// field layout, group numbers and the mask of codes that carry a source.
// assumes the register sits in the controller's extended special space.
package vim_pkg;

	localparam int          SFR_AW        = 8;
	localparam int          DATA_W        = 8;
	localparam int          GRP_W         = 4;
	localparam int          IDX_W         = 3;
	localparam int          SRC_PER_GRP   = 8;
	localparam int          LIVE_GROUPS   = 4;
	localparam int          VEC_IDX_LSB   = 1;
	localparam int          VEC_GRP_LSB   = 4;

	localparam logic [7:0]  VECTOR_ADDR   = 8'hf7;
	localparam logic [7:0]  VECTOR_RESET  = 8'h00;
	localparam logic [15:0] TRAP_LOCATION = 16'h202b;

	localparam logic [3:0]  GRP_FIRST     = 4'h1;
	localparam logic [3:0]  GRP_IN_EP     = 4'h1;
	localparam logic [3:0]  GRP_OUT_EP    = 4'h2;
	localparam logic [3:0]  GRP_USB_CTL   = 4'h3;
	localparam logic [3:0]  GRP_EP0_MISC  = 4'h4;
	localparam logic [3:0]  GRP_LAST      = 4'h4;

	localparam logic [2:0]  IDX_LAST_CTL  = 3'h4;
	localparam logic [2:0]  IDX_LAST_EP0  = 3'h5;

	localparam logic [7:0]  USED_IN_EP    = 8'hff;
	localparam logic [7:0]  USED_OUT_EP   = 8'hff;
	localparam logic [7:0]  USED_USB_CTL  = 8'h1f;
	localparam logic [7:0]  USED_EP0_MISC = 8'h3f;

endpackage

// >>> rtl/vectored_interrupt_merger.sv
// vectored interrupt merger: queues non-core event pulses per group,
// shows the best pending source as a vector, drives one low-level irq.
// assumes all event inputs are one-cycle pulses from logic on clk.
//
// Function
// RULE1: all non-core sources ORed into one request
// RULE2: merged request active low, level, while pending
// RULE3: vector code space allows up to 64 vectors
// RULE4: firmware reads vector and dispatches service routine
// RULE5: power-up or watchdog reset clears vector register
// RULE6: usb bus reset clears only with link bit
// RULE7: any qualifying reset empties the pending queue
// RULE8: vector register names source of merged interrupt
// RULE9: any write retires vector, loads next pending
// RULE10: vector bit 0 always reads zero
// RULE11: no pending interrupt reads vector all zeros
// RULE12: index in bits 3..1, group in 7..4
// RULE13: same group presented oldest arrival first
// RULE14: highest numbered pending group presented first
// RULE15: group 1 holds in endpoint ack/nack codes
// RULE16: group 2 holds out endpoint ack/nack codes
// RULE17: group 3 holds usb control event codes
// RULE18: group 4 holds endpoint 0, ata, clock wake
// RULE19: unused codes never shown, writes do not store
`timescale 1ns/10ps
`default_nettype none

module vectored_interrupt_merger (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       watchdog_reset,
	input  wire logic                       usb_bus_reset,
	input  wire logic                       function_reset_link_bit,
	input  wire logic [3:0]                 in_ep_ack,
	input  wire logic [3:0]                 in_ep_nack,
	input  wire logic [3:0]                 out_ep_ack,
	input  wire logic [3:0]                 out_ep_nack,
	input  wire logic                       setup_overwrite_event,
	input  wire logic                       setup_rx_event,
	input  wire logic                       resume_event,
	input  wire logic                       suspend_event,
	input  wire logic                       bus_reset_event,
	input  wire logic                       ep0_in_ack,
	input  wire logic                       ep0_out_ack,
	input  wire logic                       ep0_in_nack,
	input  wire logic                       ep0_out_nack,
	input  wire logic                       ata_irq_event,
	input  wire logic                       clock_wake_event,
	input  wire logic [vim_pkg::SFR_AW-1:0] sfr_addr,
	input  wire logic                       sfr_wr,
	input  wire logic                       sfr_rd,
	input  wire logic [vim_pkg::DATA_W-1:0] sfr_wdata,
	output var  logic [vim_pkg::DATA_W-1:0] sfr_rdata,
	output var  logic [vim_pkg::DATA_W-1:0] interrupt_vector,
	output var  logic                       merged_internal_irq_n
);
	import vim_pkg::*;

	// the source wiring fills four groups of eight, three bit index
	if (SRC_PER_GRP != 8 || IDX_W != 3 || LIVE_GROUPS != 4)
		begin : g_chk_group
		$error("group layout must be four groups of eight");
	end

	// group and index fields must tile the vector above bit 0
	if (VEC_IDX_LSB != 1 || VEC_GRP_LSB != VEC_IDX_LSB + IDX_W
		|| GRP_W != 4 || DATA_W != 8) begin : g_chk_fields
		$error("vector field layout does not fit");
	end

	// live groups must fit the group field and the vector space
	if (GRP_FIRST + LIVE_GROUPS - 1 > 15
		|| GRP_LAST != GRP_FIRST + LIVE_GROUPS - 1
		|| LIVE_GROUPS * SRC_PER_GRP > 64) begin : g_chk_space // RULE3
		$error("more sources than the vector space holds");
	end

	typedef logic [LIVE_GROUPS-1:0][SRC_PER_GRP-1:0]            grp_bits_t;
	typedef logic [LIVE_GROUPS-1:0][SRC_PER_GRP-1:0][IDX_W-1:0] grp_rank_t;

	grp_bits_t             arrive;
	grp_bits_t             retire;
	grp_bits_t             pend_r;
	grp_bits_t             pend_nxt;
	grp_rank_t             rank_r;
	grp_rank_t             rank_nxt;
	logic [DATA_W-1:0]     vector_r;
	logic [DATA_W-1:0]     vector_nxt;
	logic [DATA_W-1:0]     rdata_r;
	logic                  irq_n_r;
	logic                  clear_all;
	logic                  vec_wr;
	logic                  any_arrive;

	function automatic logic [3:0] count8(input logic [7:0] v);
		logic [3:0] c;
		c = 4'h0;
		for (int k = 0; k < 8; k++) begin
			c = c + {3'h0, v[k]};
		end
		return c;
	endfunction

	function automatic logic [3:0] top_group(input grp_bits_t p);
		logic [3:0] t;
		t = 4'h0;
		for (int g = 0; g < LIVE_GROUPS; g++) begin
			if (|p[g]) begin
				t = GRP_FIRST + 4'(g);
			end
		end
		return t;
	endfunction

	// unused codes are masked off at the source
	assign arrive[0] = {in_ep_nack, in_ep_ack} & USED_IN_EP; // RULE15
	assign arrive[1] = {out_ep_nack, out_ep_ack} & USED_OUT_EP; // RULE16
	assign arrive[2] = {3'h0, bus_reset_event, suspend_event,
		resume_event, setup_rx_event, setup_overwrite_event}
		& USED_USB_CTL; // RULE17
	assign arrive[3] = {2'h0, clock_wake_event, ata_irq_event,
		ep0_out_nack, ep0_in_nack, ep0_out_ack, ep0_in_ack}
		& USED_EP0_MISC; // RULE18
	assign any_arrive = |arrive;

	assign clear_all = srst | watchdog_reset
		| (usb_bus_reset & function_reset_link_bit); // RULE5 RULE6 RULE7

	// write data is ignored: any value retires the shown vector
	assign vec_wr = sfr_wr && (sfr_addr == VECTOR_ADDR); // RULE9 RULE19

	// retire only a source that is really pending
	always_comb begin
		for (int g = 0; g < LIVE_GROUPS; g++) begin
			for (int i = 0; i < SRC_PER_GRP; i++) begin
				retire[g][i] = vec_wr && pend_r[g][i]
					&& (vector_r[7:VEC_GRP_LSB] == GRP_FIRST + 4'(g))
					&& (vector_r[VEC_GRP_LSB-1:VEC_IDX_LSB] == 3'(i)); // RULE9
			end
		end
	end

	// per-group queue: rank 0 is the oldest, newcomers join the tail;
	// an arrival in the retire cycle re-queues, so the set wins
	always_comb begin
		logic [7:0] keep;
		logic [7:0] fresh;
		logic [3:0] base;
		keep  = 8'h00;
		fresh = 8'h00;
		base  = 4'h0;
		for (int g = 0; g < LIVE_GROUPS; g++) begin
			keep  = pend_r[g] & ~retire[g];
			fresh = arrive[g] & ~keep;
			base  = count8(keep);
			pend_nxt[g] = keep | fresh; // RULE1
			for (int i = 0; i < SRC_PER_GRP; i++) begin
				if (keep[i]) begin
					rank_nxt[g][i] = rank_r[g][i] - {2'h0, |retire[g]}; // RULE13
				end else if (fresh[i]) begin
					rank_nxt[g][i] = 3'(base
						+ count8(fresh & ((8'h01 << i) - 8'h01))); // RULE13
				end else begin
					rank_nxt[g][i] = 3'h0;
				end
			end
		end
	end

	// highest group wins, inside it the rank 0 entry
	always_comb begin
		vector_nxt = VECTOR_RESET; // RULE11
		for (int g = 0; g < LIVE_GROUPS; g++) begin
			for (int i = 0; i < SRC_PER_GRP; i++) begin
				if (pend_nxt[g][i] && rank_nxt[g][i] == 3'h0) begin
					vector_nxt = {GRP_FIRST + 4'(g), 3'(i), 1'b0}; // RULE12 RULE14 RULE10
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			pend_r <= '0; // RULE7
			rank_r <= '0;
		end else begin
			pend_r <= pend_nxt;
			rank_r <= rank_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			vector_r <= VECTOR_RESET; // RULE5 RULE6
		end else begin
			vector_r <= vector_nxt; // RULE8 RULE3
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= ~|pend_nxt; // RULE2 RULE1
		end
	end

	// read data is held one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_r <= VECTOR_RESET;
		end else if (sfr_rd && sfr_addr == VECTOR_ADDR) begin
			rdata_r <= vector_r; // RULE4
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign sfr_rdata             = rdata_r;
	assign interrupt_vector      = vector_r;
	assign merged_internal_irq_n = irq_n_r;

	a_irq_level_vec: assert property ( // RULE2
		@(posedge clk) disable iff (srst)
		merged_internal_irq_n == (interrupt_vector == VECTOR_RESET))
		else $error("irq level and vector disagree");

	a_vec_bit0_zero: assert property ( // RULE10
		@(posedge clk) disable iff (srst)
		interrupt_vector[0] == 1'b0)
		else $error("vector bit 0 set");

	a_unused_codes: assert property ( // RULE19
		@(posedge clk) disable iff (srst)
		interrupt_vector[7:4] <= GRP_LAST
		&& (interrupt_vector[7:4] != GRP_USB_CTL
			|| interrupt_vector[3:1] <= IDX_LAST_CTL)
		&& (interrupt_vector[7:4] != GRP_EP0_MISC
			|| interrupt_vector[3:1] <= IDX_LAST_EP0))
		else $error("unused vector code shown");

	a_wdt_clears_all: assert property ( // RULE5
		@(posedge clk) disable iff (srst)
		watchdog_reset |=> interrupt_vector == VECTOR_RESET
			&& merged_internal_irq_n && pend_r == '0)
		else $error("watchdog reset left state");

	a_usb_rst_linked: assert property ( // RULE6
		@(posedge clk) disable iff (srst)
		usb_bus_reset && function_reset_link_bit
		|=> interrupt_vector == VECTOR_RESET && pend_r == '0)
		else $error("linked usb reset did not clear");

	a_usb_rst_unlink: assert property ( // RULE6
		@(posedge clk) disable iff (srst)
		usb_bus_reset && !function_reset_link_bit && !watchdog_reset
		&& !vec_wr && interrupt_vector != VECTOR_RESET
		|=> interrupt_vector != VECTOR_RESET)
		else $error("unlinked usb reset cleared vector");

	a_write_retires: assert property ( // RULE9
		@(posedge clk) disable iff (srst)
		vec_wr && !clear_all && !any_arrive
		&& interrupt_vector != VECTOR_RESET
		|=> interrupt_vector != $past(interrupt_vector))
		else $error("write did not retire vector");

	a_event_raises: assert property ( // RULE1
		@(posedge clk) disable iff (srst)
		any_arrive && !clear_all |=> !merged_internal_irq_n)
		else $error("event did not raise irq");

	a_group_priority: assert property ( // RULE14
		@(posedge clk) disable iff (srst)
		interrupt_vector[7:4] == top_group(pend_r))
		else $error("lower group shown over higher");

	a_oldest_first: assert property ( // RULE13
		@(posedge clk) disable iff (srst)
		interrupt_vector != VECTOR_RESET |->
		rank_r[interrupt_vector[7:4] - GRP_FIRST]
			[interrupt_vector[3:1]] == 3'h0)
		else $error("vector not oldest in group");

	a_empty_reads_zero: assert property ( // RULE11
		@(posedge clk) disable iff (srst)
		pend_r == '0 |-> interrupt_vector == VECTOR_RESET)
		else $error("idle vector not zero");

	a_vec_is_pending: assert property ( // RULE8
		@(posedge clk) disable iff (srst)
		interrupt_vector != VECTOR_RESET |->
		pend_r[interrupt_vector[7:4] - GRP_FIRST][interrupt_vector[3:1]])
		else $error("shown vector not pending");

	a_irq_tracks_pend: assert property ( // RULE2
		@(posedge clk) disable iff (srst)
		merged_internal_irq_n == (pend_r == '0))
		else $error("irq level and queue disagree");

	a_srst_clears: assert property ( // RULE5
		@(posedge clk)
		srst |=> interrupt_vector == VECTOR_RESET
			&& merged_internal_irq_n && sfr_rdata == VECTOR_RESET)
		else $error("power-up reset left state");

	a_clear_empties: assert property ( // RULE7
		@(posedge clk) disable iff (srst)
		clear_all |=> pend_r == '0 && merged_internal_irq_n)
		else $error("reset left queue entries");

	a_retire_one: assert property ( // RULE9
		@(posedge clk) disable iff (srst)
		vec_wr && !clear_all && !any_arrive
		&& interrupt_vector != VECTOR_RESET
		|=> $countones(pend_r) == $countones($past(pend_r)) - 1)
		else $error("write did not retire exactly one");

	a_idle_holds: assert property ( // RULE9
		@(posedge clk) disable iff (srst)
		!vec_wr && !clear_all && !any_arrive
		|=> $stable(pend_r) && $stable(interrupt_vector))
		else $error("queue moved with no cause");

	a_set_wins: assert property ( // RULE9
		@(posedge clk) disable iff (srst)
		|(retire & arrive) && !clear_all
		|=> (pend_r & $past(retire) & $past(arrive))
			== ($past(retire) & $past(arrive)))
		else $error("arrival lost in retire cycle");

	a_rdata_vector: assert property ( // RULE8
		@(posedge clk) disable iff (srst)
		sfr_rd && sfr_addr == VECTOR_ADDR
		|=> sfr_rdata == $past(interrupt_vector))
		else $error("read data not the vector");

	a_rdata_idle: assert property ( // RULE8
		@(posedge clk) disable iff (srst)
		!(sfr_rd && sfr_addr == VECTOR_ADDR) |=> sfr_rdata == 8'h00)
		else $error("read data not zero off the vector");

	// every non-empty group keeps exactly one head entry
	for (genvar g = 0; g < LIVE_GROUPS; g++) begin : g_head_chk
		logic [SRC_PER_GRP-1:0] head;
		for (genvar i = 0; i < SRC_PER_GRP; i++) begin : g_bit
			assign head[i] = pend_r[g][i] && rank_r[g][i] == 3'h0;
		end
		a_one_head: assert property ( // RULE13
			@(posedge clk) disable iff (srst)
			$countones(head) == (|pend_r[g] ? 1 : 0))
			else $error("group queue head not unique");
	end

endmodule

`default_nettype wire

// >>> tb/fw_model.sv
// firmware side: reads the vector and retires it over the sfr strobes.
// assumes tasks are called by the bench just after a clock edge.
`timescale 1ns/10ps
`default_nettype none

module fw_model (
	input  wire logic       clk,
	input  wire logic [7:0] sfr_rdata,
	output var  logic [7:0] sfr_addr,
	output var  logic       sfr_rd,
	output var  logic       sfr_wr,
	output var  logic [7:0] sfr_wdata
);
	initial begin
		sfr_addr = 8'h00;
		sfr_rd = 1'h0;
		sfr_wr = 1'h0;
		sfr_wdata = 8'h5a;
	end

	// read the vector before dispatching a service routine
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'h1;
		@(posedge clk);
		sfr_rd <= 1'h0;
		sfr_addr <= ~a;
		#1 d = sfr_rdata;
	endtask

	// data changes every write: its value must not matter
	task automatic wr(input logic [7:0] a);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wr <= 1'h1;
		sfr_wdata <= ~sfr_wdata;
		@(posedge clk);
		sfr_wr <= 1'h0;
		sfr_addr <= ~a;
		#1;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// bench for the vectored interrupt merger with a firmware model.
// assumes one 50 MHz clock and event inputs given as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

module tb;
	import vim_pkg::*;
	logic        clk, srst, wdog, usb_rst, link, rd, wr, irq_n;
	logic [26:0] ev;
	logic [7:0]  addr, wdata, rdata, vec, d;
	int          error_cnt, checks;

	vectored_interrupt_merger vectored_interrupt_merger_i (
		.clk(clk), .srst(srst), .watchdog_reset(wdog),
		.usb_bus_reset(usb_rst), .function_reset_link_bit(link),
		.in_ep_ack(ev[3:0]), .in_ep_nack(ev[7:4]),
		.out_ep_ack(ev[11:8]), .out_ep_nack(ev[15:12]),
		.setup_overwrite_event(ev[16]), .setup_rx_event(ev[17]),
		.resume_event(ev[18]), .suspend_event(ev[19]),
		.bus_reset_event(ev[20]), .ep0_in_ack(ev[21]),
		.ep0_out_ack(ev[22]), .ep0_in_nack(ev[23]),
		.ep0_out_nack(ev[24]), .ata_irq_event(ev[25]),
		.clock_wake_event(ev[26]), .sfr_addr(addr), .sfr_wr(wr),
		.sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
		.interrupt_vector(vec), .merged_internal_irq_n(irq_n));

	fw_model fw_model_i (.clk(clk), .sfr_rdata(rdata), .sfr_addr(addr),
		.sfr_rd(rd), .sfr_wr(wr), .sfr_wdata(wdata));

	always #10 clk = ~clk;

	function automatic logic [7:0] code(int i);
		if (i < 8) return {4'h1, 3'(i), 1'h0};
		if (i < 16) return {4'h2, 3'(i - 8), 1'h0};
		if (i < 21) return {4'h3, 3'(i - 16), 1'h0};
		return {4'h4, 3'(i - 21), 1'h0};
	endfunction

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// vector and the low-active request agree with the expected code
	task automatic see(input logic [7:0] v);
		cmp(vec, v);
		cmp({7'h00, irq_n}, {7'h00, v == 8'h00});
	endtask

	task automatic pulse(int i);
		@(posedge clk);
		ev[i] <= 1'h1;
		@(posedge clk);
		ev <= '0;
		#1;
	endtask

	task automatic burst(input logic [26:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= '0;
		#1;
	endtask

	// k: 0 watchdog, 1 usb bus reset, 2 power-up reset
	task automatic kick(input int k);
		@(posedge clk);
		case (k)
			0: wdog <= 1'h1;
			1: usb_rst <= 1'h1;
			default: srst <= 1'h1;
		endcase
		@(posedge clk);
		usb_rst <= 1'h0;
		wdog <= 1'h0;
		srst <= 1'h0;
		#1;
	endtask

	task automatic t_codes();
		for (int i = 0; i < 27; i++) begin
			pulse(i);
			see(code(i));
			fw_model_i.rd(VECTOR_ADDR, d);
			cmp(d, code(i));
			fw_model_i.wr(VECTOR_ADDR);
			see(8'h00);
		end
	endtask

	task automatic t_order();
		pulse(7);
		pulse(0);
		see(8'h1e);
		pulse(25);
		see(8'h48);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h1e);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h10);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h00);
	endtask

	task automatic t_rst();
		pulse(16);
		pulse(8);
		kick(0);
		see(8'h00);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h00);
		pulse(25);
		pulse(3);
		kick(1);
		see(8'h48);
		link <= 1'h1;
		kick(1);
		see(8'h00);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h00);
		link <= 1'h0;
		pulse(5);
		kick(2);
		see(8'h00);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h00);
	endtask

	task automatic t_misc();
		pulse(26);
		fw_model_i.wr(8'hf6);
		see(8'h4a);
		fw_model_i.rd(VECTOR_ADDR, d);
		cmp(d, 8'h4a);
		@(posedge clk);
		#1 cmp(rdata, 8'h00);
		fw_model_i.rd(8'h00, d);
		cmp(d, 8'h00);
		fw_model_i.wr(VECTOR_ADDR);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h00);
	endtask

	// same-cycle arrivals: higher group first, then lowest index
	task automatic t_same();
		burst(27'h000_010a);
		see(8'h20);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h12);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h16);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h00);
	endtask

	// a repeat of a pending source is ignored; one arriving in its
	// own retire cycle goes to the tail of its group
	task automatic t_requeue();
		pulse(0);
		pulse(1);
		pulse(0);
		see(8'h10);
		fork
			fw_model_i.wr(VECTOR_ADDR);
			pulse(0);
		join
		see(8'h12);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h10);
		fw_model_i.wr(VECTOR_ADDR);
		see(8'h00);
	endtask

	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		error_cnt++;
		$display("BAD %0t timeout", $time);
		print_verdict();
	end

	initial begin
		clk = 1'h0;
		srst = 1'h1;
		wdog = 1'h0;
		usb_rst = 1'h0;
		link = 1'h0;
		ev = '0;
		repeat (10) @(posedge clk);
		srst <= 1'h0;
		#1;
		see(8'h00);
		t_codes();
		t_order();
		t_rst();
		t_misc();
		t_same();
		t_requeue();
		print_verdict();
	end
endmodule
`default_nettype wire
